/* File: hdl/cam_pkg.sv */
// Constants, field positions and types shared by the connection lookup engine
package cam_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int LCI_W = 14; // Local connection identifier width
  localparam int CFG_W = 14; // Test and configuration register width
  localparam int STAT_W = 4; // Status field width
  localparam int DATA_W = 33; // Data lines including the top parity line

  // ****************************************
  // Bus addresses (shared by several requests)
  // ****************************************
  localparam logic [3:0] ADR_RD_START = 4'h0; // Identifier for read-back, starts it
  localparam logic [3:0] ADR_RD_PP = 4'h1; // Read-back port/path (and channel in wide mode)
  localparam logic [3:0] ADR_WR_FLAGS = 4'h2; // Flags and identifier for a write
  localparam logic [3:0] ADR_WR_CH = 4'h3; // Write channel, starts the write
  localparam logic [3:0] ADR_OAM_WIDE = 4'h4; // Path search pattern in wide mode
  localparam logic [3:0] ADR_CONN_CH = 4'h5; // Connection search channel, starts it
  localparam logic [3:0] ADR_MP_CH = 4'h6; // Configured search channel, starts it
  localparam logic [3:0] ADR_RESULT = 4'h6; // Search result / flags readout
  localparam logic [3:0] ADR_CFG = 4'h7; // Test and configuration register
  localparam logic [3:0] ADR_RD_CH = 4'h9; // Read-back channel
  localparam logic [3:0] ADR_WR_PP = 4'hb; // Write port/path
  localparam logic [3:0] ADR_OAM_PP = 4'hc; // Path search port/path, starts it
  localparam logic [3:0] ADR_CONN_PP = 4'hd; // Connection search port/path
  localparam logic [3:0] ADR_MP_PP = 4'he; // Configured search port/path
  localparam logic [3:0] ADR_STATUS = 4'he; // Status word
  localparam logic [3:0] ADR_CFG_STATUS = 4'hf; // Status after a configuration request

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_VALID = 15; // Valid flag in a flags word
  localparam int BIT_PIP = 14; // Path-intermediate flag in a flags word
  localparam int BIT_PAR_NARROW = 16; // Parity line in narrow mode
  localparam int BIT_PAR_WIDE = 32; // Parity line in wide mode
  localparam int CFG_OVERWRITE = 0; // overwrite_protect_bit
  localparam int CFG_DUP = 1; // duplicate_protect_bit
  localparam int CFG_TWRITE = 2; // test_write_bit
  localparam int CFG_TREAD = 3; // test_read_bit
  localparam int CFG_TSEARCH = 4; // test_search_bit
  localparam int CFG_CH_A = 5; // channel_mask_ctrl_a
  localparam int CFG_PATH = 6; // path_mask_ctrl
  localparam int CFG_CH_B = 7; // channel_mask_ctrl_b
  localparam int CFG_FREE = 8; // free_search_bit
  localparam int CFG_WIDE_PORT = 9; // wide_port_bit: 6-bit port, 10-bit path
  localparam int CFG_PAR_CHK = 10; // parity_check_bit
  localparam int CFG_RW_BITS = 11; // Writable low bits; version sits above
  localparam int STB_FAIL = 2; // status_bit_2: request failed or refused
  localparam int STB_PARITY = 3; // status_bit_3: parity error seen

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [CFG_W-1:0] CFG_RESET = 14'h0000; // All checks and tests off
  localparam logic [STAT_W-1:0] STATUS_RESET = 4'h0; // Clean status
  localparam logic [1:0] RES_MISS = 2'h0; // status_bit_1/0: mismatch
  localparam logic [1:0] RES_SINGLE = 2'h1; // status_bit_1/0: single match
  localparam logic [1:0] RES_MULTI = 2'h3; // status_bit_1/0: multimatch

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {FSM_IDLE, FSM_SCAN, FSM_COMMIT} fsm_t;
  typedef enum logic [2:0] {REQ_NONE, REQ_OAM, REQ_CONN, REQ_MP, REQ_WRITE, REQ_READ, REQ_CFG} req_t;
  typedef struct packed {
    logic v; // entry_valid_flag
    logic pip; // path_intermediate_flag
    logic [15:0] pp; // port_number and path word
    logic [15:0] ch; // Channel word
  } entry_t;
endpackage

/* File: hdl/cam_lookup_engine.sv */
// Connection lookup engine: request decoder, memory, search scan and result registers
// Functional notes
// [RQ1] Write: identifier and flags, then pattern words
// [RQ2] Every request ends with status stored
// [RQ3] Overwrite protect refuses replacing valid entry
// [RQ4] Both protections: duplicate pattern refuses write
// [RQ5] Both protections, no duplicate: store if invalid
// [RQ6] No protection: immediate unconditional write
// [RQ7] Intermediate entries ignore channel when compared
// [RQ8] Test write stores into all banks
// [RQ9] Read-back copies line into read registers
// [RQ10] Test read reads all banks together
// [RQ11] Configured search: masked compare, result after period
// [RQ12] Mask bits drop fields; free-entry search
// [RQ13] Test search compares all banks in parallel
// [RQ14] Configuration request loads test register
// [RQ15] Path search uses port/path pattern only
// [RQ16] Several matches: lowest identifier returned
// [RQ17] Connection search with channel pattern
// [RQ18] Narrow mode odd parity on bit 16
// [RQ19] Path search narrow layout: C, 6, E
// [RQ20] Configured search narrow layout: E, 6
// [RQ21] Write narrow layout: 2, B, 3
// [RQ22] Port/path word split 4/12 or 6/10
// [RQ23] Width select: narrow or wide data lines
// [RQ24] Host waits for completion before reading
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cam_lookup_engine import cam_pkg::*; #(
  parameter int ENTRIES = 8192, // Memory lines; sets the search period
  parameter int NUM_BANKS = 4, // Memory banks used by the test requests
  parameter logic [2:0] VERSION = 3'h1 // Version readout, value arbitrary
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic bus_width_select_in,
  input wire logic [3:0] bus_address_lines_in,
  input wire logic [DATA_W-1:0] bus_data_lines_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [DATA_W-1:0] bus_read_data_out,
  output logic busy_out
);

  // ****************************************
  // Local sizes and state
  // ****************************************
  localparam int LINE_W = $clog2(ENTRIES); // Line index width
  localparam int BANK_LINES = ENTRIES / NUM_BANKS; // Lines per bank, a power of two
  localparam int OFS_W = $clog2(BANK_LINES); // Offset width within a bank

  typedef struct packed {
    fsm_t fsm; // Request sequencer
    req_t req; // Request being executed
    logic [CFG_W-1:0] cfg; // test_config_register
    logic [STAT_W-1:0] status; // Status of the last request
    logic [LCI_W-1:0] wr_lci; // local_conn_id for write or read-back
    logic wr_v; // New entry valid flag
    logic wr_pip; // New entry intermediate flag
    logic [15:0] wr_pp; // New entry port/path
    logic [15:0] wr_ch; // New entry channel
    logic [15:0] srch_pp; // Search port/path pattern
    logic [15:0] srch_ch; // Search channel pattern
    entry_t rd; // Read data register
    logic res_v; // Result valid flag
    logic res_pip; // Result intermediate flag
    logic [LCI_W-1:0] res_lci; // Result identifier
    logic [LCI_W-1:0] scan_idx; // Scan position
    logic [1:0] hits; // Mismatch / single / multi code
    logic [LCI_W-1:0] best; // Lowest matching identifier so far
    logic best_v; // Its valid flag
    logic best_pip; // Its intermediate flag
    logic par_err; // Parity error caught during the request
    logic [DATA_W-1:0] rdata; // Read data, stands one cycle
  } state_t;

  state_t q; // Current state
  state_t next_q; // Next state
  entry_t mem [ENTRIES]; // Connection memory, undefined after reset
  logic mem_we; // Write the entry this cycle
  logic mem_all; // Write the same offset in every bank
  entry_t target; // Line addressed by the stored identifier
  logic [NUM_BANKS-1:0] hit; // Per-bank compare result at the scan position
  logic [NUM_BANKS-1:0] bank_diff; // Bank differs from bank 0 at the target offset
  logic [LCI_W-1:0] cand_id [NUM_BANKS]; // Identifier of each compared line
  logic test_scan; // Scan runs bank-parallel
  logic dup_mode; // Both write protections set
  logic par_bad; // Written word failed parity
  logic [15:0] pat_pp; // Pattern port/path in use
  logic [15:0] pat_ch; // Pattern channel in use
  logic [DATA_W-1:0] rmux; // Read word with its parity line, before the register
  logic [CFG_W-1:0] cfg_view; // Configuration readout with version

  assign busy_out = (q.fsm != FSM_IDLE);
  assign bus_read_data_out = q.rdata;
  assign target = mem[q.wr_lci[LINE_W-1:0]];
  assign test_scan = (q.req != REQ_WRITE) && q.cfg[CFG_TSEARCH]; // [RQ13]
  assign dup_mode = q.cfg[CFG_OVERWRITE] && q.cfg[CFG_DUP];
  assign pat_pp = (q.req == REQ_WRITE) ? q.wr_pp : q.srch_pp;
  assign pat_ch = (q.req == REQ_WRITE) ? q.wr_ch : q.srch_ch;
  assign cfg_view = {VERSION, q.cfg[CFG_RW_BITS-1:0]}; // [RQ14]

  // Odd parity over data and address; narrow mode covers 16 data bits only [RQ18] [RQ23]
  assign par_bad = q.cfg[CFG_PAR_CHK] && (bus_width_select_in ?
    !(^{bus_data_lines_in, bus_address_lines_in}) :
    !(^{bus_data_lines_in[BIT_PAR_NARROW:0], bus_address_lines_in}));

  // ****************************************
  // Compare function
  // ****************************************
  // One line against the pattern, with the masks of the current request
  function automatic logic entry_match(entry_t e, req_t r, logic [CFG_W-1:0] c,
                                       logic [15:0] pp, logic [15:0] ch);
    logic ign_ch;
    logic ign_pp;
    logic v_ok;
    ign_ch = e.pip || (r == REQ_OAM) || ((r == REQ_MP) && (c[CFG_CH_A] || c[CFG_CH_B])); // [RQ7] [RQ15] [RQ12]
    ign_pp = (r == REQ_MP) && c[CFG_PATH]; // [RQ12]
    v_ok = ((r == REQ_MP) && c[CFG_FREE]) ? !e.v : e.v; // [RQ12]
    return v_ok && (ign_pp || (e.pp == pp)) && (ign_ch || (e.ch == ch));
  endfunction

  // ****************************************
  // Per-bank compare and test-read lanes
  // ****************************************
  // Outside test search only bank 0's lane scans, one line a cycle
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    localparam logic [LINE_W-1:0] BASE = LINE_W'(b * BANK_LINES);
    logic [LINE_W-1:0] line; // Line compared by this lane
    logic [LINE_W-1:0] tline; // Target offset in this bank
    assign line = test_scan ? (BASE | LINE_W'(q.scan_idx[OFS_W-1:0])) : q.scan_idx[LINE_W-1:0];
    assign tline = BASE | LINE_W'(q.wr_lci[OFS_W-1:0]);
    assign cand_id[b] = LCI_W'(line);
    assign hit[b] = ((b == 0) || test_scan) && entry_match(mem[line], q.req, q.cfg, pat_pp, pat_ch); // [RQ13]
    assign bank_diff[b] = (mem[tline] != mem[BASE_ZERO(tline)]); // [RQ10]
  end

  // Offset of a line within bank 0
  function automatic logic [LINE_W-1:0] BASE_ZERO(logic [LINE_W-1:0] l);
    return LINE_W'(l[OFS_W-1:0]);
  endfunction

  // ****************************************
  // Memory write port
  // ****************************************
  // A test write drops the same entry at one offset in every bank
  always_ff @(posedge ref_clk_in) begin
    if (mem_we) begin
      if (mem_all) begin
        for (int b = 0; b < NUM_BANKS; b++) begin
          mem[LINE_W'(b * BANK_LINES) | LINE_W'(q.wr_lci[OFS_W-1:0])] <= {q.wr_v, q.wr_pip, q.wr_pp, q.wr_ch}; // [RQ8]
        end
      end else begin
        mem[q.wr_lci[LINE_W-1:0]] <= {q.wr_v, q.wr_pip, q.wr_pp, q.wr_ch}; // [RQ1]
      end
    end
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  // Words are fixed while idle; reads during execution are not defined for the host
  always_comb begin
    rmux = '0;
    if (bus_width_select_in) begin
      case (bus_address_lines_in)
        ADR_RD_PP: rmux = {1'b0, q.rd.pp, q.rd.ch}; // [RQ9]
        ADR_RESULT: rmux = {13'h0000, q.status, q.res_v, q.res_pip, q.res_lci}; // [RQ2]
        ADR_CFG: rmux = {13'h0000, q.status, 2'h0, cfg_view};
        default: rmux = '0;
      endcase
      rmux[BIT_PAR_WIDE] = !(^{rmux[BIT_PAR_WIDE-1:0], bus_address_lines_in});
    end else begin
      case (bus_address_lines_in)
        ADR_RD_PP: rmux[15:0] = q.rd.pp; // [RQ9]
        ADR_RD_CH: rmux[15:0] = q.rd.ch;
        ADR_RESULT: rmux[15:0] = {q.res_v, q.res_pip, q.res_lci}; // [RQ19] [RQ20]
        ADR_STATUS, ADR_CFG_STATUS: rmux[15:0] = {12'h000, q.status}; // [RQ2]
        ADR_CFG: rmux[15:0] = {2'h0, cfg_view};
        default: rmux = '0;
      endcase
      rmux[BIT_PAR_NARROW] = !(^{rmux[BIT_PAR_NARROW-1:0], bus_address_lines_in}); // [RQ18]
    end
  end

  // ****************************************
  // Request decoder and sequencer
  // ****************************************
  always_comb begin
    next_q = q;
    mem_we = 1'b0;
    mem_all = 1'b0;
    next_q.rdata = rd_strobe_in ? rmux : '0;
    // Register loads; a start while busy is dropped so a running scan is never disturbed
    if (wr_strobe_in && (q.fsm == FSM_IDLE)) begin
      next_q.req = REQ_NONE;
      if (bus_width_select_in) begin
        case (bus_address_lines_in)
          ADR_RD_START: next_q.req = REQ_READ;
          ADR_WR_FLAGS: {next_q.wr_v, next_q.wr_pip, next_q.wr_lci} = bus_data_lines_in[15:0]; // [RQ1]
          ADR_WR_CH: begin
            {next_q.wr_pp, next_q.wr_ch} = bus_data_lines_in[31:0]; // [RQ22]
            next_q.req = REQ_WRITE;
          end
          ADR_OAM_WIDE: begin
            next_q.srch_pp = bus_data_lines_in[31:16];
            next_q.req = REQ_OAM;
          end
          ADR_CONN_CH: begin
            {next_q.srch_pp, next_q.srch_ch} = bus_data_lines_in[31:0];
            next_q.req = REQ_CONN;
          end
          ADR_MP_CH: begin
            {next_q.srch_pp, next_q.srch_ch} = bus_data_lines_in[31:0];
            next_q.req = REQ_MP;
          end
          ADR_CFG: begin
            next_q.cfg = CFG_W'(bus_data_lines_in[CFG_RW_BITS-1:0]); // [RQ14]
            next_q.req = REQ_CFG;
          end
          default: next_q.req = REQ_NONE;
        endcase
      end else begin
        case (bus_address_lines_in)
          ADR_RD_START: begin
            next_q.wr_lci = bus_data_lines_in[LCI_W-1:0]; // [RQ9]
            next_q.req = REQ_READ;
          end
          ADR_WR_FLAGS: {next_q.wr_v, next_q.wr_pip, next_q.wr_lci} = bus_data_lines_in[15:0]; // [RQ21]
          ADR_WR_PP: next_q.wr_pp = bus_data_lines_in[15:0]; // [RQ22]
          ADR_WR_CH: begin
            next_q.wr_ch = bus_data_lines_in[15:0]; // [RQ21]
            next_q.req = REQ_WRITE;
          end
          ADR_OAM_PP: begin
            next_q.srch_pp = bus_data_lines_in[15:0]; // [RQ19]
            next_q.req = REQ_OAM;
          end
          ADR_CONN_PP, ADR_MP_PP: next_q.srch_pp = bus_data_lines_in[15:0]; // [RQ20]
          ADR_CONN_CH: begin
            next_q.srch_ch = bus_data_lines_in[15:0]; // [RQ17]
            next_q.req = REQ_CONN;
          end
          ADR_MP_CH: begin
            next_q.srch_ch = bus_data_lines_in[15:0]; // [RQ20]
            next_q.req = REQ_MP;
          end
          ADR_CFG: begin
            next_q.cfg = CFG_W'(bus_data_lines_in[CFG_RW_BITS-1:0]); // [RQ14]
            next_q.req = REQ_CFG;
          end
          default: next_q.req = REQ_NONE;
        endcase
      end
      if (bus_address_lines_in == ADR_RD_START && bus_width_select_in) begin
        next_q.wr_lci = bus_data_lines_in[LCI_W-1:0];
      end
      // A new request starts clean; scans and the unchecked paths choose their route
      if (next_q.req != REQ_NONE) begin
        next_q.par_err = 1'b0;
        next_q.scan_idx = '0;
        next_q.hits = RES_MISS;
        next_q.best = '0;
        next_q.best_v = 1'b0;
        next_q.best_pip = 1'b0;
        if ((next_q.req == REQ_WRITE) && !(next_q.cfg[CFG_OVERWRITE] && next_q.cfg[CFG_DUP])) begin
          next_q.fsm = FSM_COMMIT; // [RQ6]
        end else if ((next_q.req == REQ_WRITE) && next_q.cfg[CFG_TWRITE]) begin
          next_q.fsm = FSM_COMMIT;
        end else if ((next_q.req == REQ_READ) || (next_q.req == REQ_CFG)) begin
          next_q.fsm = FSM_COMMIT;
        end else begin
          next_q.fsm = FSM_SCAN;
        end
      end
    end
    // Parity error of any write is kept until the next request start; on the starting word it beats the clear
    if (wr_strobe_in && par_bad) begin
      next_q.par_err = 1'b1; // [RQ18]
    end
    case (q.fsm)
      FSM_IDLE: begin
      end
      FSM_SCAN: begin
        // Keep the lowest identifier: a bank-parallel scan can meet higher ones first
        for (int b = 0; b < NUM_BANKS; b++) begin
          if (hit[b]) begin
            if ((next_q.hits == RES_MISS) || (cand_id[b] < next_q.best)) begin
              next_q.best = cand_id[b]; // [RQ16]
              next_q.best_v = mem[cand_id[b][LINE_W-1:0]].v;
              next_q.best_pip = mem[cand_id[b][LINE_W-1:0]].pip;
            end
            next_q.hits = (next_q.hits == RES_MISS) ? RES_SINGLE : RES_MULTI;
          end
        end
        // Fixed period: whole memory, or one bank's lines when banks run in parallel
        if (q.scan_idx == LCI_W'((test_scan ? BANK_LINES : ENTRIES) - 1)) begin
          next_q.fsm = FSM_COMMIT; // [RQ11]
        end else begin
          next_q.scan_idx = q.scan_idx + 1'b1;
        end
      end
      FSM_COMMIT: begin
        next_q.fsm = FSM_IDLE;
        next_q.res_v = 1'b0;
        next_q.res_pip = 1'b0;
        next_q.res_lci = '0;
        case (q.req)
          REQ_WRITE: begin
            if (q.cfg[CFG_TWRITE]) begin
              mem_we = 1'b1; // [RQ8]
              mem_all = 1'b1;
              next_q.status = {q.par_err, 1'b0, RES_MISS};
            end else if (dup_mode) begin
              mem_we = (q.hits == RES_MISS) && !target.v; // [RQ4] [RQ5]
              next_q.status = {q.par_err, !mem_we, q.hits};
            end else if (q.cfg[CFG_OVERWRITE]) begin
              mem_we = !target.v; // [RQ3]
              next_q.status = {q.par_err, target.v, RES_MISS};
            end else begin
              mem_we = 1'b1; // [RQ6]
              next_q.status = {q.par_err, 1'b0, RES_MISS};
            end
          end
          REQ_READ: begin
            next_q.rd = target; // [RQ9]
            next_q.res_v = target.v;
            next_q.res_pip = target.pip;
            next_q.status = {q.par_err, q.cfg[CFG_TREAD] && (|bank_diff), RES_MISS}; // [RQ10]
          end
          REQ_OAM, REQ_CONN, REQ_MP: begin
            next_q.res_v = q.best_v; // [RQ11] [RQ15]
            next_q.res_pip = q.best_pip;
            next_q.res_lci = q.best; // [RQ16]
            next_q.status = {q.par_err, 1'b0, q.hits}; // [RQ2]
          end
          default: next_q.status = {q.par_err, 1'b0, RES_MISS}; // [RQ2]
        endcase
      end
      default: next_q.fsm = FSM_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      q <= '0;
      q.fsm <= FSM_IDLE;
      q.req <= REQ_NONE;
      q.cfg <= CFG_RESET;
      q.status <= STATUS_RESET;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_unchecked_write: assert property ((q.fsm == FSM_COMMIT && q.req == REQ_WRITE && !q.cfg[CFG_OVERWRITE]) // [RQ6]
    |-> mem_we) else $error("unprotected write not stored");
  a_protect_refuse: assert property ((q.fsm == FSM_COMMIT && q.req == REQ_WRITE && !q.cfg[CFG_TWRITE] // [RQ3]
    && q.cfg[CFG_OVERWRITE] && target.v) |-> !mem_we ##1 q.status[STB_FAIL]) else $error("valid entry overwritten");
  a_dup_refuse: assert property ((q.fsm == FSM_COMMIT && q.req == REQ_WRITE && !q.cfg[CFG_TWRITE] // [RQ4]
    && dup_mode && q.hits != RES_MISS) |-> !mem_we) else $error("duplicate pattern written");
  a_dup_store: assert property ((q.fsm == FSM_COMMIT && q.req == REQ_WRITE && !q.cfg[CFG_TWRITE] // [RQ5]
    && dup_mode && q.hits == RES_MISS && !target.v) |-> mem_we) else $error("checked write not stored");
  a_test_write: assert property ((q.fsm == FSM_COMMIT && q.req == REQ_WRITE && q.cfg[CFG_TWRITE]) // [RQ8]
    |-> mem_we && mem_all) else $error("test write missed banks");
  a_scan_finish: assert property ((q.fsm == FSM_SCAN && !test_scan // [RQ11]
    && q.scan_idx == LCI_W'(ENTRIES - 1)) |=> q.fsm == FSM_COMMIT ##1 q.fsm == FSM_IDLE)
    else $error("search period wrong");
  a_lowest_kept: assert property ((q.fsm == FSM_SCAN && q.hits != RES_MISS) |=> q.best <= $past(q.best)) // [RQ16]
    else $error("higher identifier replaced lower");
  a_pip_ignore: assert property ((q.fsm == FSM_SCAN && q.req == REQ_CONN && mem[cand_id[0][LINE_W-1:0]].v // [RQ7]
    && mem[cand_id[0][LINE_W-1:0]].pip && mem[cand_id[0][LINE_W-1:0]].pp == q.srch_pp) |-> hit[0])
    else $error("channel compared on intermediate entry");
  a_parity_flag: assert property ((wr_strobe_in && par_bad) |=> q.par_err) // [RQ18]
    else $error("parity error lost");
  a_read_copy: assert property ((q.fsm == FSM_COMMIT && q.req == REQ_READ) |=> q.rd == $past(target)) // [RQ9]
    else $error("read-back data not copied");

endmodule
`default_nettype wire

/* File: test/host_bus_model.sv */
// Host side word former: adds the odd parity line to each narrow or wide bus word
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic wide_in,
  input wire logic flip_in,
  input wire logic [3:0] adr_in,
  input wire logic [31:0] word_in,
  output logic [32:0] bus_out
);
  // Parity makes data plus address odd; flip_in spoils it to provoke the error path
  assign bus_out = wide_in ? {~^{word_in, adr_in} ^ flip_in, word_in} :
    {16'h0000, ~^{word_in[15:0], adr_in} ^ flip_in, word_in[15:0]};
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the connection lookup engine on the narrow and wide bus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cam_pkg::*;
  logic ref_clk_in = 1'b0, reset_n_in = 1'b0, wr = 1'b0, rd = 1'b0; // Clock, reset, strobes
  logic wide = 1'b0, bad = 1'b0; // Bus width select, parity corruption
  logic [3:0] adr = 4'h0; // Request address
  logic [31:0] word = 32'h00000000; // Word before parity
  logic [32:0] bus, rdata; // Bus word, read word
  logic busy; // Request running
  int n_fail = 0, samples_checked = 0; // Mismatches and comparisons
  // ****************************************
  // Clock, device and host model
  // ****************************************
  initial begin
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  cam_lookup_engine #(.ENTRIES(16), .NUM_BANKS(4)) dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .bus_width_select_in(wide), .bus_address_lines_in(adr), .bus_data_lines_in(bus), .wr_strobe_in(wr),
    .rd_strobe_in(rd), .bus_read_data_out(rdata), .busy_out(busy));
  host_bus_model host (.wide_in(wide), .flip_in(bad), .adr_in(adr), .word_in(word), .bus_out(bus));
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    adr <= a;
    word <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask
  // Masked read; parity is judged only on full-word reads
  task automatic get(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    logic p;
    p = wide ? (&m) : (&m[15:0]);
    @(posedge ref_clk_in);
    adr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    @(negedge ref_clk_in);
    chk(wide ? {rdata[32] & p, rdata[31:0] & m} : {rdata[32:17], rdata[16] & p, rdata[15:0] & m[15:0]},
      wide ? {~^{e, a} & p, e & m} : {16'h0000, ~^{e[15:0], a} & p, e[15:0] & m[15:0]});
  endtask
  // Results are only read once busy has dropped, within a bound
  task automatic settle();
    int k;
    k = 0;
    @(negedge ref_clk_in);
    while (busy === 1'b1 && k < 100) begin
      @(negedge ref_clk_in);
      k++;
    end
    chk({32'h00000000, busy}, 33'h000000000);
  endtask
  task automatic wreq(input logic [13:0] id, input logic v, input logic i, input logic [15:0] pp, ch);
    put(ADR_WR_FLAGS, {v, i, id});
    put(ADR_WR_PP, pp);
    put(ADR_WR_CH, ch);
    settle();
  endtask
  task automatic rback(input logic [13:0] id, input logic [15:0] pp, ch, fl);
    put(ADR_RD_START, {2'b00, id});
    settle();
    get(ADR_RD_PP, pp, 16'hffff);
    get(ADR_RD_CH, ch, 16'hffff);
    get(ADR_RESULT, fl, 16'hffff);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_store();
    get(ADR_CFG, 16'h0800, 16'hffff);
    for (int n = 0; n < 16; n++) begin
      wreq(n[13:0], 1'b0, 1'b0, 16'h0000, 16'h0000);
    end
    wreq(14'd3, 1'b1, 1'b0, 16'h3a5c, 16'h0123);
    wreq(14'd1, 1'b1, 1'b1, 16'h3a5c, 16'h0456);
    rback(14'd3, 16'h3a5c, 16'h0123, 16'h8000);
    get(ADR_STATUS, 16'h0000, 16'h0004);
    $display("store and read-back done");
  endtask
  task automatic t_search();
    put(ADR_CONN_PP, 16'h3a5c);
    put(ADR_CONN_CH, 16'h0123);
    settle();
    get(ADR_RESULT, 16'hc001, 16'hffff);
    get(ADR_STATUS, 16'h0003, 16'h000f);
    put(ADR_OAM_PP, 16'h3a5c);
    settle();
    get(ADR_RESULT, 16'hc001, 16'hffff);
    get(ADR_STATUS, 16'h0003, 16'h000f);
    put(ADR_MP_PP, 16'h3a5c);
    put(ADR_MP_CH, 16'h0456);
    settle();
    get(ADR_RESULT, 16'hc001, 16'hffff);
    get(ADR_STATUS, 16'h0001, 16'h000f);
    $display("searches done");
  endtask
  // Wide bus: whole pattern in one word, status beside the result
  task automatic t_wide();
    @(posedge ref_clk_in);
    wide <= 1'b1;
    put(ADR_WR_FLAGS, 32'h00008007);
    put(ADR_WR_CH, 32'h4c4c0abc);
    settle();
    put(ADR_CONN_CH, 32'h4c4c0abc);
    settle();
    get(ADR_RESULT, 32'h00018007, 32'hffffffff);
    @(posedge ref_clk_in);
    wide <= 1'b0;
    $display("wide bus done");
  endtask
  task automatic t_protect();
    put(ADR_CFG, 16'h0400);
    settle();
    // A spoiled starting word must show up in the status of its own request
    @(posedge ref_clk_in);
    bad <= 1'b1;
    put(ADR_RD_START, 16'h0003);
    bad <= 1'b0;
    settle();
    get(ADR_STATUS, 16'h0008, 16'h0008);
    put(ADR_CFG, 16'h0001);
    settle();
    wreq(14'd3, 1'b1, 1'b0, 16'h5b01, 16'h0456);
    get(ADR_STATUS, 16'h0004, 16'h0004);
    put(ADR_CFG, 16'h0003);
    settle();
    wreq(14'd5, 1'b1, 1'b0, 16'h3a5c, 16'h0123);
    get(ADR_STATUS, 16'h0004, 16'h0004);
    wreq(14'd5, 1'b1, 1'b0, 16'h5b01, 16'h0789);
    get(ADR_STATUS, 16'h0000, 16'h0004);
    rback(14'd3, 16'h3a5c, 16'h0123, 16'h8000);
    put(ADR_CFG, 16'h0004);
    settle();
    wreq(14'd2, 1'b1, 1'b0, 16'h1111, 16'h2222);
    for (int b = 0; b < 4; b++) begin
      rback(14'd2 + 14'd4 * b[13:0], 16'h1111, 16'h2222, 16'h8000);
    end
    // Line 5 differs from its bank-0 twin, so a test read reports a failure
    put(ADR_CFG, 16'h0008);
    settle();
    rback(14'd5, 16'h5b01, 16'h0789, 16'h8000);
    get(ADR_STATUS, 16'h0004, 16'h0004);
    // Bank-parallel masked search: four lanes hit in one cycle, four cycles of scan
    put(ADR_CFG, 16'h0030);
    settle();
    put(ADR_MP_PP, 16'h1111);
    put(ADR_MP_CH, 16'h0000);
    repeat (6) @(negedge ref_clk_in);
    chk({32'h00000000, busy}, 33'h000000000);
    get(ADR_RESULT, 16'h8002, 16'hffff);
    get(ADR_STATUS, 16'h0003, 16'h000f);
    $display("protection and test write done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    t_store();
    t_search();
    t_wide();
    t_protect();
    close_out();
  end
  // Watchdog: the full run needs far less than this span
  initial begin
    #50000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
